// [lbh_regs.svh]
/*
  Constants of the local bus host port: decode windows, field positions, timing.
  Assumes inclusion by the design files of the host port only.
*/
`ifndef LBH_REGS_SVH
`define LBH_REGS_SVH

`define LBH_MEM_BASE 26'h0000000
`define LBH_MEM_MASK 26'h3000000
`define LBH_IO_BASE 14'h0F00
`define LBH_IO_MASK 14'h3F00
`define LBH_IO_LSB 2
`define LBH_IO_MSB 15
`define LBH_MEM_DEPTH_LOG2 6
`define LBH_WAIT_NS 8
`define LBH_CLK_NS 4
`define LBH_WAIT_CYC ((`LBH_WAIT_NS + `LBH_CLK_NS - 1) / `LBH_CLK_NS)

`endif

// [lbh_pkg.sv]
/*
  Types of the local bus host port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lbh_pkg;
  typedef enum logic [2:0] {
    LBH_IDLE = 3'b000,
    LBH_DECODE = 3'b001,
    LBH_WAIT = 3'b010,
    LBH_DONE = 3'b011,
    LBH_HOLD = 3'b100
  } lbh_state_t;
endpackage

// [lbh_mem.sv]
/*
  Small word store with per-byte write enables and a registered read port.
  Assumes one clock and synchronous inputs.
*/
`timescale 1ns/100ps
`default_nettype none
module lbh_mem #(
  parameter int AW = 6
) (
  input wire logic clk_sys, // System clock
  input wire logic [AW-1:0] addr, // Word address
  input wire logic [3:0] wr_lane, // Byte write enables, active high
  input wire logic [31:0] wr_data, // Write data
  input wire logic rd_en, // Read strobe
  output logic [31:0] rd_data // Registered read data
);
  if (AW < 1 || AW > 16)
  begin : g_bad_param
    $error("lbh_mem: unsupported address width");
  end

  // One byte-wide store per lane, so each lane has a single writer
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      logic [7:0] lane_q [0:(1<<AW)-1];

      always_ff @(posedge clk_sys)
      begin
        if (wr_lane[g])
          lane_q[addr] <= wr_data[8*g +: 8];
      end

      always_ff @(posedge clk_sys)
      begin
        if (rd_en)
          rd_data[8*g +: 8] <= lane_q[addr];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [lbh_irq.sv]
/*
  Pending-event holder driving the interrupt request level.
  Assumes events are one-cycle pulses and acknowledge is a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module lbh_irq (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic event_in, // Interrupting condition pulse
  input wire logic ack_in, // Acknowledge pulse
  output logic pending // Condition pending
);
  // Set wins over a simultaneous acknowledge
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      pending <= 1'b0;
    else if (event_in)
      pending <= 1'b1;
    else if (ack_in)
      pending <= 1'b0;
  end
endmodule
`default_nettype wire

// [lbh_host_port.sv]
/*
  Local bus slave port: claims memory and I/O cycles, terminates them,
  honours the ready-return input and raises an interrupt request.
  Assumes all host signals synchronous to clk_sys, the local bus clock.
*/
// Functional notes
// - Data travels on a 32-bit two-way bus; driven on reads, sampled on writes.
// - Memory decode uses address bits 27:2 qualified by upper address select.
// - I/O decode uses only address bits 15:2.
// - Four active-low lane enables pick the bytes moved.
// - Memory/IO select low means I/O, high means memory.
// - Write/read qualifier low means read, high means write.
// - Decoding starts when the address strobe is sampled low.
// - All sampling and driving follows the local bus clock.
// - Cycle and read data are held while ready-return stays high.
// - Local claim goes low for cycles aimed at this device.
// - Cycle done goes low to end a claimed cycle.
// - Reset high holds the port in its initial state.
// - Interrupt request is active while a condition is pending.
`include "lbh_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module lbh_host_port #(
  parameter int WAIT_CYC = `LBH_WAIT_CYC,
  parameter int MEM_AW = `LBH_MEM_DEPTH_LOG2
) (
  input wire logic clk_sys, // Local bus clock
  input wire logic reset, // Async reset, active high
  input wire logic [27:2] host_addr, // Host address bits 27:2
  input wire logic upper_addr_select, // Upper address decode hit
  input wire logic lane3_enable_n, // Byte lane 3 enable, low active
  input wire logic lane2_enable_n, // Byte lane 2 enable, low active
  input wire logic lane1_enable_n, // Byte lane 1 enable, low active
  input wire logic lane0_enable_n, // Byte lane 0 enable, low active
  input wire logic mem_io_select, // High memory, low I/O
  input wire logic write_read, // High write, low read
  input wire logic addr_strobe_n, // Address strobe, low active
  input wire logic cycle_return_n, // Ready return, low active
  input wire logic [31:0] data_in, // Data bus level
  output logic [31:0] data_out, // Data bus drive value
  output logic data_oe, // Data bus output enable
  output logic local_claim_n, // Cycle claimed, low active
  output logic cycle_done_n, // Cycle done, low active
  output logic cycle_done_oe, // Cycle done drive enable
  output logic irq_n // Interrupt request, low active
);
  if (WAIT_CYC < 1 || WAIT_CYC > 15 || MEM_AW < 1 || MEM_AW > 12)
  begin : g_bad_param
    $error("lbh_host_port: unsupported parameters");
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic strobe = !addr_strobe_n;
  wire logic mem_hit = mem_io_select && upper_addr_select &&
    ((host_addr & `LBH_MEM_MASK) == `LBH_MEM_BASE);
  wire logic [13:0] io_addr = host_addr[`LBH_IO_MSB:`LBH_IO_LSB];
  wire logic io_hit = !mem_io_select &&
    ((io_addr & `LBH_IO_MASK) == `LBH_IO_BASE);
  wire logic hit = strobe && (mem_hit || io_hit);
  wire logic [3:0] lanes = ~{lane3_enable_n, lane2_enable_n,
    lane1_enable_n, lane0_enable_n};

  // ----------------------------------------
  // Cycle state
  // ----------------------------------------
  lbh_pkg::lbh_state_t state_q, state_d;
  logic [3:0] wait_q, wait_d;
  logic [MEM_AW-1:0] addr_q;
  logic [3:0] lanes_q;
  logic write_q;
  logic [31:0] wdata_q;
  logic io_q;

  wire logic wait_end = (wait_q == 4'h0);
  wire logic ret_ok = !cycle_return_n;

  always_comb
  begin
    state_d = state_q;
    wait_d = wait_q;
    case (state_q)
      lbh_pkg::LBH_IDLE:
      begin
        if (hit)
        begin
          state_d = lbh_pkg::LBH_WAIT;
          wait_d = 4'(WAIT_CYC - 1);
        end
      end
      lbh_pkg::LBH_WAIT:
      begin
        if (wait_end)
          state_d = lbh_pkg::LBH_DONE;
        else
          wait_d = wait_q - 4'h1;
      end
      lbh_pkg::LBH_DONE:
        state_d = ret_ok ? lbh_pkg::LBH_IDLE : lbh_pkg::LBH_HOLD;
      lbh_pkg::LBH_HOLD:
        if (ret_ok)
          state_d = lbh_pkg::LBH_IDLE;
      default:
        state_d = lbh_pkg::LBH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_q <= lbh_pkg::LBH_IDLE;
      wait_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      wait_q <= wait_d;
    end
  end

  wire logic start = (state_q == lbh_pkg::LBH_IDLE) && hit;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      addr_q <= '0;
      lanes_q <= 4'h0;
      write_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      io_q <= 1'b0;
    end
    else if (start)
    begin
      addr_q <= host_addr[MEM_AW+1:2];
      lanes_q <= lanes;
      write_q <= write_read;
      wdata_q <= data_in;
      io_q <= !mem_io_select;
    end
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  wire logic in_wait = (state_q == lbh_pkg::LBH_WAIT);
  wire logic [3:0] wr_lane = (in_wait && wait_end && write_q) ? lanes_q : 4'h0;
  // Read launched at the strobe so the word stands ready when done is driven
  wire logic rd_en = start && !write_read;
  wire logic [MEM_AW-1:0] mem_addr = start ? host_addr[MEM_AW+1:2] : addr_q;
  logic [31:0] rd_word;

  lbh_mem #(.AW(MEM_AW)) u_mem (
    .clk_sys(clk_sys),
    .addr(mem_addr),
    .wr_lane(wr_lane),
    .wr_data(wdata_q),
    .rd_en(rd_en),
    .rd_data(rd_word)
  );

  wire logic [31:0] lane_mask = {{8{lanes_q[3]}}, {8{lanes_q[2]}},
    {8{lanes_q[1]}}, {8{lanes_q[0]}}};

  // ----------------------------------------
  // Interrupt: raised by a completed I/O write, cleared by an I/O read
  // ----------------------------------------
  wire logic done_now = (state_q == lbh_pkg::LBH_DONE);
  wire logic irq_set = done_now && io_q && write_q;
  wire logic irq_clr = done_now && io_q && !write_q;
  logic pending;

  lbh_irq u_irq (
    .clk_sys(clk_sys),
    .reset(reset),
    .event_in(irq_set),
    .ack_in(irq_clr),
    .pending(pending)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  wire logic busy_d = (state_d != lbh_pkg::LBH_IDLE);
  wire logic drive_d = busy_d && !write_q && (state_d != lbh_pkg::LBH_WAIT);

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      local_claim_n <= 1'b1;
      cycle_done_n <= 1'b1;
      cycle_done_oe <= 1'b0;
      data_oe <= 1'b0;
      data_out <= 32'h0000_0000;
      irq_n <= 1'b1;
    end
    else
    begin
      local_claim_n <= !(busy_d || start);
      cycle_done_n <= !(state_d == lbh_pkg::LBH_DONE);
      cycle_done_oe <= busy_d;
      data_oe <= drive_d && (state_q != lbh_pkg::LBH_IDLE);
      if (state_q == lbh_pkg::LBH_WAIT && wait_end)
        data_out <= 32'h0000_0000;
      else if (state_q == lbh_pkg::LBH_DONE && !write_q)
        data_out <= data_out;
      if (state_d == lbh_pkg::LBH_DONE && !write_q)
        data_out <= rd_word & lane_mask;
      irq_n <= !pending;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_claim_hit;
    @(posedge clk_sys) disable iff (reset)
    (state_q == lbh_pkg::LBH_IDLE && !hit) |=> local_claim_n;
  endproperty
  a_claim_hit: assert property (p_claim_hit) else $error("claim without hit");

  property p_claim_start;
    @(posedge clk_sys) disable iff (reset)
    start |=> !local_claim_n;
  endproperty
  a_claim_start: assert property (p_claim_start) else $error("hit not claimed");

  property p_done_time;
    @(posedge clk_sys) disable iff (reset)
    start |-> ##[1:16] !cycle_done_n;
  endproperty
  a_done_time: assert property (p_done_time) else $error("cycle not terminated");

  property p_done_claimed;
    @(posedge clk_sys) disable iff (reset)
    !cycle_done_n |-> !local_claim_n;
  endproperty
  a_done_claimed: assert property (p_done_claimed) else $error("done on unclaimed");

  property p_hold_read;
    @(posedge clk_sys) disable iff (reset)
    (state_q == lbh_pkg::LBH_HOLD && cycle_return_n) |=> (data_oe == $past(data_oe))
      && $stable(data_out);
  endproperty
  a_hold_read: assert property (p_hold_read) else $error("read data dropped");

  property p_no_drive_write;
    @(posedge clk_sys) disable iff (reset)
    data_oe |-> !write_q;
  endproperty
  a_no_drive_write: assert property (p_no_drive_write) else $error("drove on write");

  property p_io_decode;
    @(posedge clk_sys) disable iff (reset)
    (strobe && !mem_io_select && state_q == lbh_pkg::LBH_IDLE &&
      ((io_addr & `LBH_IO_MASK) != `LBH_IO_BASE)) |=> local_claim_n;
  endproperty
  a_io_decode: assert property (p_io_decode) else $error("bad I/O claim");

  property p_mem_qual;
    @(posedge clk_sys) disable iff (reset)
    (strobe && mem_io_select && !upper_addr_select &&
      state_q == lbh_pkg::LBH_IDLE) |=> local_claim_n;
  endproperty
  a_mem_qual: assert property (p_mem_qual) else $error("claim without select");

  property p_irq;
    @(posedge clk_sys) disable iff (reset)
    irq_set |-> ##2 !irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_reset_out;
    @(posedge clk_sys)
    reset |=> (local_claim_n && cycle_done_n && !data_oe);
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs active in reset");

  property p_done_oe;
    @(posedge clk_sys) disable iff (reset)
    !local_claim_n |-> cycle_done_oe;
  endproperty
  a_done_oe: assert property (p_done_oe) else $error("done not driven in cycle");

  property p_read_drive;
    @(posedge clk_sys) disable iff (reset)
    (!cycle_done_n && !write_q) |-> data_oe;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");

  property p_irq_clear;
    @(posedge clk_sys) disable iff (reset)
    irq_clr |-> ##2 irq_n;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");

  property p_miss_no_done;
    @(posedge clk_sys) disable iff (reset)
    (state_q == lbh_pkg::LBH_IDLE && !hit) |=> cycle_done_n;
  endproperty
  a_miss_no_done: assert property (p_miss_no_done) else $error("done on miss");

  c_io: cover property (@(posedge clk_sys) start && !mem_io_select);
  c_read: cover property (@(posedge clk_sys) start && !write_read);
  c_write: cover property (@(posedge clk_sys) start && write_read);
  c_hold: cover property (@(posedge clk_sys) state_q == lbh_pkg::LBH_HOLD);
  c_irq: cover property (@(posedge clk_sys) !irq_n);
endmodule
`default_nettype wire

// [lbh_host_model.sv]
/*
  Host bus master model that runs one local bus cycle per call of cycle().
  Assumes the port answers on clk_sys and the data bus has pull-ups.
*/
`timescale 1ns/100ps
`default_nettype none
module lbh_host_model (
  input wire logic clk_sys, // Local bus clock
  output logic [27:2] host_addr, // Address
  output logic upper_addr_select, // Upper decode hit
  output logic [3:0] lane_n, // Lane enables, low active
  output logic mem_io_select, // High memory
  output logic write_read, // High write
  output logic addr_strobe_n, // Strobe, low active
  output logic cycle_return_n, // Ready return, low active
  output logic [31:0] data_in, // Resolved data bus
  input wire logic [31:0] data_out, // Device drive value
  input wire logic data_oe, // Device drive enable
  input wire logic local_claim_n, // Claim
  input wire logic cycle_done_n, // Done
  input wire logic cycle_done_oe // Done drive enable
);
  logic [31:0] drv_q = 32'h0;
  logic drv_en = 1'b0;

  // Released bus floats to the pull-up level
  assign data_in = data_oe ? data_out : (drv_en ? drv_q : 32'hFFFFFFFF);

  initial
  begin
    {host_addr, upper_addr_select, lane_n, mem_io_select, write_read} = 33'h0;
    addr_strobe_n = 1'b1;
    cycle_return_n = 1'b1;
  end

  task automatic cycle(input logic [25:0] a, input logic sel, mio, wr,
    input logic [3:0] ln, input logic [31:0] wd, input int hold,
    output logic [31:0] rd, output logic hit, output int lat, output logic ok);
    int n;
    @(posedge clk_sys);
    #1;
    host_addr = a;
    upper_addr_select = sel;
    lane_n = ln;
    mem_io_select = mio;
    write_read = wr;
    drv_q = wd;
    drv_en = wr;
    addr_strobe_n = 1'b0;
    cycle_return_n = (hold == 0) ? 1'b0 : 1'b1;
    @(posedge clk_sys);
    #1;
    addr_strobe_n = 1'b1;
    hit = 1'b0;
    ok = 1'b1;
    rd = 32'h0;
    n = 1;
    while (cycle_done_n !== 1'b0 && n < 10)
    begin
      hit = hit | (local_claim_n === 1'b0);
      @(posedge clk_sys);
      #1;
      n++;
    end
    lat = n;
    hit = hit | (local_claim_n === 1'b0);
    if (n < 10)
    begin
      rd = data_in;
      ok = ok & (cycle_done_oe === 1'b1);
      // Stall: claim and read data must stand until return goes low
      repeat (hold)
      begin
        @(posedge clk_sys);
        #1;
        ok = ok & (local_claim_n === 1'b0) & (data_oe === !wr) & (data_in === rd);
        ok = ok & (cycle_done_n === 1'b1) & (cycle_done_oe === 1'b1);
      end
      cycle_return_n = 1'b0;
      @(posedge clk_sys);
      #1;
      ok = ok & (local_claim_n === 1'b1) & (data_oe === 1'b0) & (cycle_done_oe === 1'b0);
    end
    drv_en = 1'b0;
    cycle_return_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// [lbh_host_port_bench.sv]
/*
  Self-checking bench of the local bus host port.
  Assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module lbh_host_port_bench;
  localparam int WC = 2;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [27:2] host_addr;
  logic [3:0] lane_n;
  logic [31:0] data_in, data_out, rd;
  logic sel, mio, wr, strobe_n, ret_n, data_oe, claim_n, done_n, done_oe, irq_n, hit, ok;
  int lat;
  int mismatches = 0;
  int check_count = 0;

  always #2 clk_sys = ~clk_sys;

  lbh_host_port #(.WAIT_CYC(WC)) i_lbh_host_port (.clk_sys(clk_sys), .reset(reset),
    .host_addr(host_addr), .upper_addr_select(sel), .lane3_enable_n(lane_n[3]),
    .lane2_enable_n(lane_n[2]), .lane1_enable_n(lane_n[1]), .lane0_enable_n(lane_n[0]),
    .mem_io_select(mio), .write_read(wr), .addr_strobe_n(strobe_n),
    .cycle_return_n(ret_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .local_claim_n(claim_n), .cycle_done_n(done_n), .cycle_done_oe(done_oe), .irq_n(irq_n));

  lbh_host_model i_lbh_host_model (.clk_sys(clk_sys), .host_addr(host_addr),
    .upper_addr_select(sel), .lane_n(lane_n), .mem_io_select(mio), .write_read(wr),
    .addr_strobe_n(strobe_n), .cycle_return_n(ret_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .local_claim_n(claim_n), .cycle_done_n(done_n),
    .cycle_done_oe(done_oe));

  // ----------------------------------------------------------------
  // Compare, cycle and closing tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One cycle; checks claim, stall behaviour and done latency
  task automatic run(input logic [25:0] a, input logic s, m, w, input logic [3:0] ln,
    input logic [31:0] wd, input int hold, input logic exp_hit);
    i_lbh_host_model.cycle(a, s, m, w, ln, wd, hold, rd, hit, lat, ok);
    chk({30'h0, exp_hit, 1'b1}, {30'h0, hit, ok});
    if (exp_hit)
      chk(32'(1 + WC), 32'(lat));
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_mem();
    run(26'h5, 1, 1, 1, 4'h0, 32'hA5C31E77, 0, 1);
    run(26'h5, 1, 1, 1, 4'hA, 32'h11223344, 0, 1);
    run(26'h5, 1, 1, 0, 4'h0, 32'h0, 3, 1);
    chk(32'hA5221E44, rd);
    run(26'h5, 1, 1, 0, 4'h3, 32'h0, 0, 1);
    chk(32'hA5220000, rd);
  endtask

  task automatic t_miss();
    run(26'h5, 0, 1, 1, 4'h0, 32'h0, 0, 0);
    run(26'h2000005, 1, 1, 1, 4'h0, 32'h0, 0, 0);
    run(26'h5, 1, 1, 0, 4'h0, 32'h0, 1, 1);
    chk(32'hA5221E44, rd);
  endtask

  task automatic t_io();
    run(26'h040F01, 0, 0, 1, 4'h0, 32'h1, 0, 1);
    @(posedge clk_sys);
    #1;
    chk(32'h0, {31'h0, irq_n});
    run(26'h000380, 0, 0, 0, 4'h0, 32'h0, 0, 0);
    run(26'h000F01, 0, 0, 0, 4'h0, 32'h0, 2, 1);
    chk(32'h1, {31'h0, irq_n});
    run(26'h000F01, 1, 1, 1, 4'h0, 32'h0, 0, 1);
    @(posedge clk_sys);
    #1;
    chk(32'h1, {31'h0, irq_n});
  endtask

  task automatic t_reset_mid();
    run(26'h000F01, 0, 0, 1, 4'h0, 32'h0, 0, 1);
    @(posedge clk_sys);
    #1;
    chk(32'h0, {31'h0, irq_n});
    reset = 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(32'hD, {28'h0, claim_n, done_n, data_oe, irq_n});
    #1;
    reset = 1'b0;
    run(26'h5, 1, 1, 0, 4'h0, 32'h0, 0, 1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_sys);
    chk(32'hD, {28'h0, claim_n, done_n, data_oe, irq_n});
    #1;
    reset = 1'b0;
    t_mem();
    t_miss();
    t_io();
    t_reset_mid();
    test_done();
  end

  initial
  begin
    #10000;
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
